/* hw/flash_pe_pkg.sv */
// constants for the flash program and erase controller
package flash_pe_pkg;
    localparam logic [15:0] CTRL_IDX     = 16'hFE08;
    localparam logic [15:0] PROT_IDX     = 16'hFF7E;
    localparam logic [15:0] TRIM_HI_IDX  = 16'hFF80;
    localparam logic [15:0] TRIM_LO_IDX  = 16'hFF81;
    localparam logic [15:0] VEC_IDX      = 16'hFFDC;
    localparam logic [15:0] USER_LO_IDX  = 16'hC000;
    localparam logic [15:0] USER_HI_IDX  = 16'hFDFF;
    localparam logic [15:0] VEC_PAGE_IDX = 16'hFFC0;
    localparam logic [13:0] VEC_ERASE_LO = 14'h3F80;
    localparam logic [13:0] ARRAY_LO     = 14'h0000;
    localparam logic [13:0] ARRAY_HI     = 14'h3FFF;
    localparam logic [13:0] PAGE_MASK    = 14'h003F;
    localparam logic [13:0] ROW_MASK     = 14'h001F;
    localparam logic [1:0]  PROT_TOP     = 2'h3;
    localparam logic [5:0]  PROT_LOW     = 6'h00;
    localparam int          PGM_BIT      = 0;
    localparam int          ERASE_BIT    = 1;
    localparam int          MASS_BIT     = 2;
    localparam int          HIGH_VOLTAGE_ON_BIT     = 3;
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [7:0]  PROT_RESET   = 8'hFF;
    localparam logic [7:0]  PROT_NONE    = 8'hFF;
    localparam logic [7:0]  ERASED_BYTE  = 8'hFF;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

/* hw/flash_array_mem.sv */
// byte array of the flash with registered read and program-by-and writes
`timescale 1ns/10ps
module flash_array_mem #(
    parameter int AW = 14
) (
    // clock
    input  wire logic          clk,
    // read port
    input  wire logic [AW-1:0] readAddr,
    output logic      [7:0]    readData,
    // write port
    input  wire logic          writeEn,
    input  wire logic          andMode,
    input  wire logic [AW-1:0] writeAddr,
    input  wire logic [7:0]    writeData
);
    logic [7:0] mem [0:(1<<AW)-1];

    // programming only clears bits, erase writes all ones
    always_ff @(posedge clk) begin
        if (writeEn) begin
            mem[writeAddr] <= andMode ? (mem[writeAddr] & writeData) : writeData;
        end
    end

    // registered read data
    always_ff @(posedge clk) begin
        readData <= mem[readAddr];
    end
endmodule

/* hw/flash_program_erase_control.sv */
// flash program and erase sequencer with protection, behind an AXI4-Lite slave
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module flash_program_erase_control #(
    parameter int ADDR_W = 18
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // write address and data
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // read address and data
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // pin and status
    input  wire logic              testHighVoltage,
    output logic                   chargePumpOn,
    output logic                   eraseBusy
);
    function automatic logic isMapped(input logic [15:0] a);
        return (a >= flash_pe_pkg::USER_LO_IDX && a <= flash_pe_pkg::USER_HI_IDX)
            || a == flash_pe_pkg::CTRL_IDX || a == flash_pe_pkg::PROT_IDX
            || a == flash_pe_pkg::TRIM_HI_IDX || a == flash_pe_pkg::TRIM_LO_IDX
            || a >= flash_pe_pkg::VEC_IDX;
    endfunction

    // all ones opens everything, zero gives start C000
    function automatic logic isProtected(input logic [15:0] a, input logic [7:0] bits);
        return bits != flash_pe_pkg::PROT_NONE
            && a >= {flash_pe_pkg::PROT_TOP, bits, flash_pe_pkg::PROT_LOW};
    endfunction

    logic [7:0]  ctrl_reg;
    logic [7:0]  protect_reg;
    logic        tvMeta_reg;
    logic        tvSync_reg;
    logic        awHeld_reg;
    logic        wHeld_reg;
    logic [15:0] wrIdx_reg;
    logic [7:0]  wrByte_reg;
    logic        wrLane_reg;
    logic        protectSeen_reg;
    logic        latched_reg;
    logic [15:0] latchAddr_reg;
    logic        sweepOn_reg;
    logic [13:0] sweepAddr_reg;
    logic [13:0] sweepEnd_reg;
    logic        rdPend_reg;
    logic [15:0] rdIdx_reg;
    logic [7:0]  memRead;
    logic        awTake;
    logic        wTake;
    logic        arTake;
    logic        doWrite;
    logic        ctrlWrite;
    logic        ctrlOk;
    logic        flashWrite;
    logic        progWrite;
    logic        startSweep;
    logic        targetProt;
    logic        seqOk;
    logic        hvAllowed;
    logic        protPage;
    logic [13:0] sweepStart;
    logic [13:0] sweepStop;
    logic        memWriteEn;
    logic [13:0] memWriteAddr;
    logic [7:0]  memWriteData;

    assign awTake  = s_axi_awvalid & s_axi_awready;
    assign wTake   = s_axi_wvalid & s_axi_wready;
    assign arTake  = s_axi_arvalid & s_axi_arready;
    assign doWrite = awHeld_reg & wHeld_reg & ~s_axi_bvalid & ~sweepOn_reg;

    // decode of the held write
    assign ctrlWrite  = doWrite & wrLane_reg & wrIdx_reg == flash_pe_pkg::CTRL_IDX;
    // refuse a write selecting program and erase together
    assign ctrlOk     = ctrlWrite & ~(wrByte_reg[flash_pe_pkg::PGM_BIT]
                                      & wrByte_reg[flash_pe_pkg::ERASE_BIT]);
    assign flashWrite = doWrite & wrLane_reg & isMapped(wrIdx_reg)
                        & wrIdx_reg != flash_pe_pkg::CTRL_IDX;
    // program only inside the latched row, outside protection
    assign progWrite  = flashWrite & ctrl_reg[flash_pe_pkg::PGM_BIT]
                        & ctrl_reg[flash_pe_pkg::HIGH_VOLTAGE_ON_BIT]
                        & (wrIdx_reg[13:0] & ~flash_pe_pkg::ROW_MASK)
                          == (latchAddr_reg[13:0] & ~flash_pe_pkg::ROW_MASK)
                        & ~isProtected(wrIdx_reg, protect_reg);

    // high voltage qualification
    assign protPage   = latchAddr_reg[15:6] == flash_pe_pkg::PROT_IDX[15:6];
    // target inside protected range, test voltage opens the protect page
    assign targetProt = isProtected(latchAddr_reg, protect_reg) & ~(tvSync_reg & protPage);
    // mass erase needs protect byte all ones
    assign seqOk      = protectSeen_reg & latched_reg
                    & ((wrByte_reg[flash_pe_pkg::ERASE_BIT] & wrByte_reg[flash_pe_pkg::MASS_BIT])
                       ? protect_reg == flash_pe_pkg::PROT_NONE : ~targetProt);
    // high voltage only with a selection and completed sequence
    assign hvAllowed  = (wrByte_reg[flash_pe_pkg::PGM_BIT] | wrByte_reg[flash_pe_pkg::ERASE_BIT])
                        & seqOk;

    // erase runs when erase is cleared while high voltage is on
    assign startSweep = ctrlOk & ctrl_reg[flash_pe_pkg::ERASE_BIT]
                        & ctrl_reg[flash_pe_pkg::HIGH_VOLTAGE_ON_BIT]
                        & ~wrByte_reg[flash_pe_pkg::ERASE_BIT];

    // erase range selection
    always_comb begin
        if (ctrl_reg[flash_pe_pkg::MASS_BIT]) begin
            sweepStart = flash_pe_pkg::ARRAY_LO;
            sweepStop  = flash_pe_pkg::ARRAY_HI;
        end else if (latchAddr_reg >= flash_pe_pkg::VEC_PAGE_IDX) begin
            // vector page takes the trim bytes with it
            sweepStart = flash_pe_pkg::VEC_ERASE_LO;
            sweepStop  = flash_pe_pkg::ARRAY_HI;
        end else begin
            sweepStart = latchAddr_reg[13:0] & ~flash_pe_pkg::PAGE_MASK;
            sweepStop  = latchAddr_reg[13:0] | flash_pe_pkg::PAGE_MASK;
        end
    end

    // test voltage pin synchroniser
    always_ff @(posedge clk) begin
        if (srst) begin
            tvMeta_reg <= 1'b0;
            tvSync_reg <= 1'b0;
        end else begin
            tvMeta_reg <= testHighVoltage;
            tvSync_reg <= tvMeta_reg;
        end
    end

    // write address and data capture, response
    always_ff @(posedge clk) begin
        if (srst) begin
            awHeld_reg    <= 1'b0;
            wHeld_reg     <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= flash_pe_pkg::RESP_OKAY;
            wrIdx_reg     <= 16'h0000;
            wrByte_reg    <= 8'h00;
            wrLane_reg    <= 1'b0;
        end else begin
            if (awTake) begin
                wrIdx_reg <= s_axi_awaddr[17:2];
            end
            if (wTake) begin
                wrByte_reg <= s_axi_wdata[7:0];
                wrLane_reg <= s_axi_wstrb[0];
            end
            awHeld_reg    <= doWrite ? 1'b0 : (awHeld_reg | awTake);
            wHeld_reg     <= doWrite ? 1'b0 : (wHeld_reg | wTake);
            s_axi_awready <= doWrite | ~(awHeld_reg | awTake);
            s_axi_wready  <= doWrite | ~(wHeld_reg | wTake);
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= isMapped(wrIdx_reg) ? flash_pe_pkg::RESP_OKAY
                                                    : flash_pe_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // control register
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_reg <= flash_pe_pkg::CTRL_RESET;
        end else if (ctrlOk) begin
            ctrl_reg <= {4'h0,
                         wrByte_reg[flash_pe_pkg::HIGH_VOLTAGE_ON_BIT]
                         & (ctrl_reg[flash_pe_pkg::HIGH_VOLTAGE_ON_BIT] | hvAllowed),
                         wrByte_reg[2:0]};
        end
    end

    // sequence tracking: protect read and latching write
    always_ff @(posedge clk) begin
        if (srst) begin
            protectSeen_reg <= 1'b0;
            latched_reg     <= 1'b0;
            latchAddr_reg   <= 16'h0000;
        end else if (ctrlOk && wrByte_reg[2:0] != ctrl_reg[2:0]) begin
            protectSeen_reg <= 1'b0;
            latched_reg     <= 1'b0;
        end else if ((ctrl_reg[flash_pe_pkg::PGM_BIT] || ctrl_reg[flash_pe_pkg::ERASE_BIT])
                     && !ctrl_reg[flash_pe_pkg::HIGH_VOLTAGE_ON_BIT]) begin
            if (rdPend_reg && rdIdx_reg == flash_pe_pkg::PROT_IDX) begin
                protectSeen_reg <= 1'b1;
            end
            // first flash write latches the target
            // the protect location also serves as a latch target
            if (flashWrite && !latched_reg) begin
                latched_reg   <= 1'b1;
                latchAddr_reg <= wrIdx_reg;
            end
        end
    end

    // protect byte, nonvolatile in the array, held here
    always_ff @(posedge clk) begin
        if (srst) begin
            protect_reg <= flash_pe_pkg::PROT_RESET;
        end else if (tvSync_reg) begin
            // changes only with test voltage present
            if (startSweep && (ctrl_reg[flash_pe_pkg::MASS_BIT] || protPage)) begin
                protect_reg <= flash_pe_pkg::ERASED_BYTE;
            end else if (progWrite && wrIdx_reg == flash_pe_pkg::PROT_IDX) begin
                protect_reg <= protect_reg & wrByte_reg;
            end
        end
    end

    // erase sweep, one byte a cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            sweepOn_reg   <= 1'b0;
            sweepAddr_reg <= flash_pe_pkg::ARRAY_LO;
            sweepEnd_reg  <= flash_pe_pkg::ARRAY_LO;
        end else if (startSweep) begin
            sweepOn_reg   <= 1'b1;
            sweepAddr_reg <= sweepStart;
            sweepEnd_reg  <= sweepStop;
        end else if (sweepOn_reg) begin
            sweepOn_reg   <= sweepAddr_reg != sweepEnd_reg;
            sweepAddr_reg <= sweepAddr_reg + 14'h0001;
        end
    end

    // erase writes ones, program ands in zeros
    always_comb begin
        memWriteEn   = sweepOn_reg | (progWrite & wrIdx_reg != flash_pe_pkg::PROT_IDX);
        memWriteAddr = sweepOn_reg ? sweepAddr_reg : wrIdx_reg[13:0];
        memWriteData = sweepOn_reg ? flash_pe_pkg::ERASED_BYTE : wrByte_reg;
    end

    flash_array_mem #(
        .AW (14)
    ) flash_array_mem_inst (
        .clk       (clk),
        .readAddr  (s_axi_araddr[15:2]),
        .readData  (memRead),
        .writeEn   (memWriteEn),
        .andMode   (~sweepOn_reg),
        .writeAddr (memWriteAddr),
        .writeData (memWriteData)
    );

    // read channel: array read takes one cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= flash_pe_pkg::RESP_OKAY;
            rdPend_reg    <= 1'b0;
            rdIdx_reg     <= 16'h0000;
        end else begin
            s_axi_arready <= ~arTake & ~rdPend_reg & (~s_axi_rvalid | s_axi_rready);
            rdPend_reg    <= arTake;
            if (arTake) begin
                rdIdx_reg <= s_axi_araddr[17:2];
            end
            if (rdPend_reg) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= isMapped(rdIdx_reg) ? flash_pe_pkg::RESP_OKAY
                                                    : flash_pe_pkg::RESP_SLVERR;
                if (!isMapped(rdIdx_reg)) begin
                    s_axi_rdata <= 32'h00000000;
                end else if (rdIdx_reg == flash_pe_pkg::CTRL_IDX) begin
                    s_axi_rdata <= {24'h000000, ctrl_reg};
                end else if (rdIdx_reg == flash_pe_pkg::PROT_IDX) begin
                    s_axi_rdata <= {24'h000000, protect_reg};
                end else begin
                    s_axi_rdata <= {24'h000000, memRead};
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // status outputs straight from flops
    assign chargePumpOn = ctrl_reg[flash_pe_pkg::HIGH_VOLTAGE_ON_BIT];
    assign eraseBusy    = sweepOn_reg;

    // checks
    interlock_keep_a: assert property (@(posedge clk) disable iff (srst)
        ctrlWrite && wrByte_reg[0] && wrByte_reg[1] |=> $stable(ctrl_reg))
        else $error("write selecting program and erase was taken");
    hv_sequence_a: assert property (@(posedge clk) disable iff (srst)
        $rose(ctrl_reg[3]) |-> $past(protectSeen_reg) && $past(latched_reg)
                               && (ctrl_reg[0] || ctrl_reg[1]))
        else $error("high voltage set without sequence");
    mass_block_a: assert property (@(posedge clk) disable iff (srst)
        $rose(ctrl_reg[3]) && ctrl_reg[2] && ctrl_reg[1] |-> protect_reg == 8'hFF)
        else $error("mass erase high voltage while protected");
    protect_hv_a: assert property (@(posedge clk) disable iff (srst)
        $rose(ctrl_reg[3]) && !ctrl_reg[2] |-> !$past(targetProt))
        else $error("high voltage set for protected target");
    row_bound_a: assert property (@(posedge clk) disable iff (srst)
        memWriteEn && !sweepOn_reg |-> memWriteAddr[13:5] == latchAddr_reg[13:5])
        else $error("program outside latched row");
    protect_change_a: assert property (@(posedge clk) disable iff (srst)
        !$stable(protect_reg) |-> $past(tvSync_reg))
        else $error("protect byte changed without test voltage");
    vector_erase_a: assert property (@(posedge clk) disable iff (srst)
        startSweep && !ctrl_reg[2] && latchAddr_reg >= 16'hFFC0
        |=> sweepOn_reg && sweepAddr_reg == 14'h3F80 ##1 sweepAddr_reg == 14'h3F81)
        else $error("vector page erase misses trim bytes");
    page_erase_a: assert property (@(posedge clk) disable iff (srst)
        startSweep && !ctrl_reg[2] && latchAddr_reg < 16'hFFC0
        |=> sweepAddr_reg[5:0] == 6'h00 && sweepEnd_reg[5:0] == 6'h3F)
        else $error("page erase not aligned to 64 bytes");
    read_latency_a: assert property (@(posedge clk) disable iff (srst)
        arTake |-> ##2 s_axi_rvalid)
        else $error("read answer not two cycles after address");
endmodule

/* dv/flash_program_erase_control_bench.sv */
// self-checking bench for the flash program and erase controller
`timescale 1ns/10ps
module flash_program_erase_control_bench;
    logic        clk;
    logic        srst;
    logic [17:0] awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [17:0] araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    logic        testHighVoltage;
    logic        chargePumpOn;
    logic        eraseBusy;
    int          n_fail;
    int          num_checks;
    int          cycles;
    localparam logic [15:0] CTRL = flash_pe_pkg::CTRL_IDX;
    localparam logic [15:0] PROT = flash_pe_pkg::PROT_IDX;

    flash_program_erase_control #(.ADDR_W(18)) flash_program_erase_control_inst (
        .clk(clk), .srst(srst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .testHighVoltage(testHighVoltage), .chargePumpOn(chargePumpOn), .eraseBusy(eraseBusy)
    );

    // clock generation
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // one register write; address and data offered together, released when taken
    task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
        bit ad;
        bit wd;
        ad = 0;
        wd = 0;
        @(posedge clk);
        awaddr  <= {idx, 2'b00};
        wdata   <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clk);
            if (awvalid && awready) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wd = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, er);
    endtask

    // one register read compared with its expected byte
    task automatic rd(input logic [15:0] idx, input logic [7:0] exp, input logic [1:0] er = 2'h0);
        @(posedge clk);
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, {24'h000000, exp});
        chk(rresp, er);
    endtask

    logic [7:0] protExp;

    // select, read the protect byte, then latch a target
    task automatic arm(input logic [7:0] sel, input logic [15:0] tgt);
        wr(CTRL, sel);
        rd(PROT, protExp);
        wr(tgt, 8'h00);
    endtask

    // program one byte with a full row sequence
    task automatic prog(input logic [15:0] idx, input logic [7:0] d);
        arm(8'h01, idx);
        wr(CTRL, 8'h09);
        wr(idx, d);
        wr(CTRL, 8'h08);
        wr(CTRL, 8'h00);
    endtask

    // erase sequence; the final write stalls until the sweep ends
    task automatic ers(input logic [7:0] sel, input logic [15:0] tgt);
        arm(sel, tgt);
        wr(CTRL, sel | 8'h08);
        chk(chargePumpOn, 1'b1);
        wr(CTRL, 8'h08);
        chk(eraseBusy, 1'b1);
        wr(CTRL, 8'h00);
        chk(eraseBusy, 1'b0);
    endtask

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            end_of_test();
        end
    end

    // main sequence
    initial begin
        n_fail = 0;
        num_checks = 0;
        cycles = 0;
        protExp = 8'hFF;
        srst = 1'b1;
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready, testHighVoltage} = '0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rd(CTRL, 8'h00);
        rd(PROT, 8'hFF);
        rd(16'h0000, 8'h00, 2'h2);
        wr(16'hFE00, 8'h55, 2'h2);
        wr(CTRL, 8'h01);
        wr(CTRL, 8'h03);
        rd(CTRL, 8'h01);
        wr(CTRL, 8'h09);
        rd(CTRL, 8'h01);
        chk(chargePumpOn, 1'b0);
        wr(CTRL, 8'h00);
        ers(8'h06, 16'hC000);
        rd(16'hC000, 8'hFF);
        rd(16'hFFDC, 8'hFF);
        prog(16'hC020, 8'hA5);
        arm(8'h01, 16'hC020);
        wr(CTRL, 8'h09);
        wr(16'hC03F, 8'h3C);
        wr(16'hC040, 8'h00);
        wr(CTRL, 8'h08);
        wr(CTRL, 8'h00);
        rd(16'hC020, 8'hA5);
        rd(16'hC03F, 8'h3C);
        rd(16'hC040, 8'hFF);
        prog(16'hC040, 8'h5A);
        ers(8'h02, 16'hC030);
        rd(16'hC020, 8'hFF);
        rd(16'hC040, 8'h5A);
        prog(16'hFF80, 8'h12);
        rd(16'hFF80, 8'h12);
        ers(8'h02, 16'hFFDC);
        rd(16'hFF80, 8'hFF);
        // protect byte moves only under the test voltage
        testHighVoltage <= 1'b1;
        repeat (4) @(posedge clk);
        prog(PROT, 8'h03);
        testHighVoltage <= 1'b0;
        repeat (4) @(posedge clk);
        protExp = 8'h03;
        rd(PROT, 8'h03);
        prog(PROT, 8'h00);
        rd(PROT, 8'h03);
        arm(8'h01, 16'hC0C0);
        wr(CTRL, 8'h09);
        rd(CTRL, 8'h01);
        wr(CTRL, 8'h00);
        arm(8'h01, 16'hC080);
        wr(CTRL, 8'h09);
        rd(CTRL, 8'h09);
        wr(16'hC080, 8'h77);
        wr(CTRL, 8'h08);
        wr(CTRL, 8'h00);
        rd(16'hC080, 8'h77);
        arm(8'h06, PROT);
        wr(CTRL, 8'h0E);
        rd(CTRL, 8'h06);
        wr(CTRL, 8'h00);
        end_of_test();
    end
endmodule
